//--- upcin_pkg.sv
/*
 * upcin_pkg: constants, register map and carrier types of the uart pin
 * control and serial-state notification block.
 * assumes: every user names items as upcin_pkg::name, nothing imported.
 */
package upcin_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int NPINS  = 6;
    localparam int REG_W  = 16;
    localparam int IRQ_W  = 3;
    localparam int IDX_W  = 10;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PIN_CLEAR  = 10'h04F;
    localparam logic [IDX_W-1:0] IDX_PIN_STATUS = 10'h050;
    localparam logic [IDX_W-1:0] IDX_PIN_MASK   = 10'h051;
    localparam logic [IDX_W-1:0] IDX_FMT_SEL    = 10'h052;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 10'h053;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h054;

    ////////////////////////////////////////////////////////////////////////
    // reset values and fields
    localparam logic [NPINS-1:0] PINS_RST     = 6'h00;
    localparam logic [REG_W-1:0] REG_RST      = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST      = 3'h0;
    localparam int               FMT_CUST_BIT = 0;
    localparam int               IRQ_PIN_CHG  = 0;
    localparam int               IRQ_SERIAL   = 1;
    localparam int               IRQ_PKT_DONE = 2;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    ////////////////////////////////////////////////////////////////////////
    // notification packet
    localparam logic [7:0]  PKT_REQ_TYPE  = 8'hA1;
    localparam logic [7:0]  PKT_NOTIF_SS  = 8'h20;
    localparam logic [15:0] PKT_W_VALUE   = 16'h0000;
    localparam logic [15:0] PKT_W_INDEX   = 16'h0000;
    localparam logic [15:0] PKT_W_LEN_STD = 16'h0002;
    localparam logic [15:0] PKT_W_LEN_CUS = 16'h0004;
    localparam logic [3:0]  OFS_REQ_TYPE  = 4'h0;
    localparam logic [3:0]  OFS_NOTIF     = 4'h1;
    localparam logic [3:0]  OFS_VALUE_LO  = 4'h2;
    localparam logic [3:0]  OFS_VALUE_HI  = 4'h3;
    localparam logic [3:0]  OFS_INDEX_LO  = 4'h4;
    localparam logic [3:0]  OFS_INDEX_HI  = 4'h5;
    localparam logic [3:0]  OFS_LEN_LO    = 4'h6;
    localparam logic [3:0]  OFS_LEN_HI    = 4'h7;
    localparam logic [3:0]  OFS_DATA0     = 4'h8;
    localparam logic [3:0]  OFS_DATA1     = 4'h9;
    localparam logic [3:0]  OFS_DATA2     = 4'hA;
    localparam logic [3:0]  OFS_DATA3     = 4'hB;
    localparam logic [3:0]  OFS_FIRST     = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic overrun;
        logic parity;
        logic framing;
        logic ring;
        logic brk;
        logic dsr;
        logic dcd;
    } upcin_serial_s;

    localparam int SER_W = $bits(upcin_serial_s);

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } upcin_pkt_s;

endpackage

//--- upcin_pin_sync.sv
/*
 * upcin_pin_sync: three-stage synchroniser for the uart-side pins with an
 * agreement filter on the last two stages.
 * assumes: d_i is asynchronous to clk_sys_i; clk_en_i freezes all stages.
 */
module upcin_pin_sync (
    // clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      arst_n_i,
    input  wire logic                      clk_en_i,
    // pins
    input  wire logic [upcin_pkg::NPINS-1:0] d_i,
    output logic      [upcin_pkg::NPINS-1:0] q_o
);

    logic [upcin_pkg::NPINS-1:0] s1_reg;
    logic [upcin_pkg::NPINS-1:0] s2_reg;
    logic [upcin_pkg::NPINS-1:0] s3_reg;
    logic [upcin_pkg::NPINS-1:0] q_reg;
    logic [upcin_pkg::NPINS-1:0] q_next;

    ////////////////////////////////////////////////////////////////////////
    // a level counts only once stages two and three agree
    always_comb begin
        for (int i = 0; i < upcin_pkg::NPINS; i++) begin
            q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_reg <= upcin_pkg::PINS_RST;
            s2_reg <= upcin_pkg::PINS_RST;
            s3_reg <= upcin_pkg::PINS_RST;
            q_reg  <= upcin_pkg::PINS_RST;
        end else if (clk_en_i) begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg  <= q_next;
        end
    end

    assign q_o = q_reg;

endmodule

//--- upcin_top.sv
/*
 * upcin_top: six uart-side general purpose pins with clear strobe, level
 * status and per-pin change masks, plus the serial-state notification
 * packet generator for the usb interrupt channel.
 * assumes: an ahb-lite master with single word transfers; uart status
 * inputs and pin set/direction come from logic on clk_sys_i; the usb
 * endpoint drains packet bytes with a valid/ready handshake.
 */

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - writing one clears an output pin low
// - status read returns present level of pins
// - unmasked pin change issues notification packet
// - masked pin change issues no packet
// - status and customized packets carry current levels; standard packets carry no pin levels
// - format bit selects standard or customized packet
// - first byte is request type 0xA1
// - second byte is serial-state code 0x20
// - value and index words are zero
// - length two standard, four customized data
// - data word bit layout, top bits zero
// - overrun set when receive data discarded
// - framing and parity bits report errors
// - break and ring bits follow present state
// - dsr and carrier bits follow input levels
module upcin_top (
    // clock, reset, enable
    input  wire logic                        clk_sys_i,
    input  wire logic                        arst_n_i,
    input  wire logic                        clk_en_i,
    // ahb-lite slave
    input  wire logic                        hsel_i,
    input  wire logic [31:0]                 haddr_i,
    input  wire logic [1:0]                  htrans_i,
    input  wire logic                        hwrite_i,
    input  wire logic [2:0]                  hsize_i,
    input  wire logic [31:0]                 hwdata_i,
    input  wire logic                        hready_i,
    output logic      [31:0]                 hrdata_o,
    output logic                             hreadyout_o,
    output logic                             hresp_o,
    // uart-side pins
    input  wire logic [upcin_pkg::NPINS-1:0] pin_in_i,
    input  wire logic [upcin_pkg::NPINS-1:0] pin_dir_i,
    input  wire logic [upcin_pkg::NPINS-1:0] pin_set_i,
    output logic      [upcin_pkg::NPINS-1:0] pin_out_o,
    output logic      [upcin_pkg::NPINS-1:0] pin_oe_o,
    // uart serial state
    input  wire logic                        rx_overrun_i,
    input  wire logic                        rx_parity_err_i,
    input  wire logic                        rx_framing_err_i,
    input  wire logic                        ring_det_i,
    input  wire logic                        break_det_i,
    input  wire logic                        dsr_i,
    input  wire logic                        dcd_i,
    // notification packet stream
    output logic                             pkt_valid_o,
    input  wire logic                        pkt_ready_i,
    output logic      [7:0]                  pkt_data_o,
    output logic                             pkt_last_o,
    // interrupt
    output logic                             irq_o
);

    localparam int N = upcin_pkg::NPINS;

    typedef enum logic {
        ST_IDLE,
        ST_SEND
    } upcin_state_e;

    ////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic hit(input logic [31:0]          a,
                                 input logic [upcin_pkg::IDX_W-1:0] idx);
        hit = (a == {20'h00000, idx, 2'h0});
    endfunction

    function automatic logic [7:0] pkt_byte(
        input logic [3:0]                      ofs,
        input logic                            cust,
        input logic [upcin_pkg::REG_W-1:0]     word,
        input logic [N-1:0]                    pins);
        logic [15:0] len;
        len = cust ? upcin_pkg::PKT_W_LEN_CUS : upcin_pkg::PKT_W_LEN_STD;
        case (ofs)
            upcin_pkg::OFS_REQ_TYPE: pkt_byte = upcin_pkg::PKT_REQ_TYPE;
            upcin_pkg::OFS_NOTIF:    pkt_byte = upcin_pkg::PKT_NOTIF_SS;
            upcin_pkg::OFS_VALUE_LO: pkt_byte = upcin_pkg::PKT_W_VALUE[7:0];
            upcin_pkg::OFS_VALUE_HI: pkt_byte = upcin_pkg::PKT_W_VALUE[15:8];
            upcin_pkg::OFS_INDEX_LO: pkt_byte = upcin_pkg::PKT_W_INDEX[7:0];
            upcin_pkg::OFS_INDEX_HI: pkt_byte = upcin_pkg::PKT_W_INDEX[15:8];
            upcin_pkg::OFS_LEN_LO:   pkt_byte = len[7:0];
            upcin_pkg::OFS_LEN_HI:   pkt_byte = len[15:8];
            upcin_pkg::OFS_DATA0:    pkt_byte = word[7:0];
            upcin_pkg::OFS_DATA1:    pkt_byte = word[15:8];
            upcin_pkg::OFS_DATA2:    pkt_byte = {2'h0, pins};
            upcin_pkg::OFS_DATA3:    pkt_byte = 8'h00;
            default:                 pkt_byte = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins and change detection
    logic [N-1:0] pin_lvl;
    logic [N-1:0] pin_prev_reg;

    upcin_pin_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .clk_en_i  (clk_en_i),
        .d_i       (pin_in_i),
        .q_o       (pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [N-1:0]                pin_out_reg,  pin_out_next;
    logic [N-1:0]                mask_reg,     mask_next;
    logic                        fmt_reg,      fmt_next;
    logic [upcin_pkg::IRQ_W-1:0] irq_st_reg,   irq_st_next;
    logic [upcin_pkg::IRQ_W-1:0] irq_msk_reg,  irq_msk_next;
    logic                        wr_pend_reg,  wr_pend_next;
    logic [31:0]                 wr_addr_reg,  wr_addr_next;
    logic [31:0]                 hrdata_reg,   hrdata_next;
    logic [N-1:0]                prev_next;

    // packet engine state
    upcin_state_e                state_reg,    state_next;
    logic                        pend_reg,     pend_next;
    logic [3:0]                  ofs_reg,      ofs_next;
    logic                        cust_reg,     cust_next;
    logic [upcin_pkg::REG_W-1:0] word_reg,     word_next;
    logic [N-1:0]                snap_reg,     snap_next;
    logic [2:0]                  err_reg,      err_next;
    logic [3:0]                  lvl_prev_reg, lvl_prev_next;
    upcin_pkg::upcin_pkt_s       out_reg,      out_next;

    ////////////////////////////////////////////////////////////////////////
    // event sources
    logic                   addr_ok;
    logic                   rd_take;
    logic                   clr_wr;
    logic [N-1:0]           pin_chg;
    logic                   pin_trig;
    logic [3:0]             lvl_now;
    logic                   ser_trig;
    logic                   pkt_done;
    upcin_pkg::upcin_serial_s ser;

    assign addr_ok  = hsel_i && hready_i &&
                      (htrans_i == upcin_pkg::HTRANS_NONSEQ);
    assign rd_take  = addr_ok && !hwrite_i;
    assign clr_wr   = wr_pend_reg &&
                      hit(wr_addr_reg, upcin_pkg::IDX_PIN_CLEAR);
    assign pin_chg  = pin_lvl ^ pin_prev_reg;
    assign pin_trig = |(pin_chg & ~mask_reg);
    assign lvl_now  = {ring_det_i, break_det_i, dsr_i, dcd_i};
    // errors are pulses; levels trigger on change only
    assign ser_trig = rx_overrun_i || rx_parity_err_i || rx_framing_err_i ||
                      (lvl_now != lvl_prev_reg);
    assign pkt_done = (state_reg == ST_SEND) && pkt_ready_i && out_reg.last;

    ////////////////////////////////////////////////////////////////////////
    // bus and register group
    always_comb begin
        pin_out_next = pin_out_reg;
        mask_next    = mask_reg;
        fmt_next     = fmt_reg;
        irq_msk_next = irq_msk_reg;
        irq_st_next  = irq_st_reg;
        wr_pend_next = addr_ok && hwrite_i;
        wr_addr_next = addr_ok ? haddr_i : wr_addr_reg;
        hrdata_next  = hrdata_reg;
        prev_next    = pin_lvl;

        // sibling set strobes first, so a clear in the same cycle wins
        pin_out_next = pin_out_next | (pin_set_i & pin_dir_i);
        if (clr_wr) begin
            pin_out_next = pin_out_next & ~(hwdata_i[N-1:0] & pin_dir_i);
        end
        if (wr_pend_reg) begin
            if (hit(wr_addr_reg, upcin_pkg::IDX_PIN_MASK)) begin
                mask_next = hwdata_i[N-1:0];
            end
            if (hit(wr_addr_reg, upcin_pkg::IDX_FMT_SEL)) begin
                fmt_next = hwdata_i[upcin_pkg::FMT_CUST_BIT];
            end
            if (hit(wr_addr_reg, upcin_pkg::IDX_IRQ_MASK)) begin
                irq_msk_next = hwdata_i[upcin_pkg::IRQ_W-1:0];
            end
        end

        if (rd_take) begin
            hrdata_next = 32'h0000_0000;
            if (hit(haddr_i, upcin_pkg::IDX_PIN_STATUS)) begin
                hrdata_next[N-1:0] = pin_lvl;
            end
            if (hit(haddr_i, upcin_pkg::IDX_PIN_MASK)) begin
                hrdata_next[N-1:0] = mask_reg;
            end
            if (hit(haddr_i, upcin_pkg::IDX_FMT_SEL)) begin
                hrdata_next[upcin_pkg::FMT_CUST_BIT] = fmt_reg;
            end
            if (hit(haddr_i, upcin_pkg::IDX_IRQ_MASK)) begin
                hrdata_next[upcin_pkg::IRQ_W-1:0] = irq_msk_reg;
            end
            if (hit(haddr_i, upcin_pkg::IDX_IRQ_STATUS)) begin
                hrdata_next[upcin_pkg::IRQ_W-1:0] = irq_st_reg;
                irq_st_next = upcin_pkg::IRQ_RST;
            end
        end
        // set wins over the read clear
        if (pin_trig) begin
            irq_st_next[upcin_pkg::IRQ_PIN_CHG] = 1'b1;
        end
        if (ser_trig) begin
            irq_st_next[upcin_pkg::IRQ_SERIAL] = 1'b1;
        end
        if (pkt_done) begin
            irq_st_next[upcin_pkg::IRQ_PKT_DONE] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_reg  <= upcin_pkg::PINS_RST;
            mask_reg     <= upcin_pkg::PINS_RST;
            fmt_reg      <= 1'b0;
            irq_st_reg   <= upcin_pkg::IRQ_RST;
            irq_msk_reg  <= upcin_pkg::IRQ_RST;
            wr_pend_reg  <= 1'b0;
            wr_addr_reg  <= 32'h0000_0000;
            hrdata_reg   <= 32'h0000_0000;
            pin_prev_reg <= upcin_pkg::PINS_RST;
        end else if (clk_en_i) begin
            pin_out_reg  <= pin_out_next;
            mask_reg     <= mask_next;
            fmt_reg      <= fmt_next;
            irq_st_reg   <= irq_st_next;
            irq_msk_reg  <= irq_msk_next;
            wr_pend_reg  <= wr_pend_next;
            wr_addr_reg  <= wr_addr_next;
            hrdata_reg   <= hrdata_next;
            pin_prev_reg <= prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // packet engine group
    always_comb begin
        state_next    = state_reg;
        pend_next     = pend_reg;
        ofs_next      = ofs_reg;
        cust_next     = cust_reg;
        word_next     = word_reg;
        snap_next     = snap_reg;
        err_next      = err_reg;
        lvl_prev_next = lvl_now;
        out_next      = out_reg;

        // sticky errors until a packet reports them
        ser         = '0;
        ser.overrun = err_reg[2] || rx_overrun_i;
        ser.parity  = err_reg[1] || rx_parity_err_i;
        ser.framing = err_reg[0] || rx_framing_err_i;
        ser.ring    = ring_det_i;
        ser.brk     = break_det_i;
        ser.dsr     = dsr_i;
        ser.dcd     = dcd_i;
        err_next    = {ser.overrun, ser.parity, ser.framing};

        // a single pending flag: further events merge into it
        if (pin_trig || ser_trig) begin
            pend_next = 1'b1;
        end

        case (state_reg)
            ST_IDLE: begin
                if (pend_reg) begin
                    // snapshot so the packet is self-consistent
                    cust_next = fmt_reg;
                    word_next = {{(upcin_pkg::REG_W - upcin_pkg::SER_W){1'b0}},
                                 ser};
                    snap_next = pin_lvl;
                    err_next  = 3'h0;
                    if (!(pin_trig || ser_trig)) begin
                        pend_next = 1'b0;
                    end
                    ofs_next      = upcin_pkg::OFS_FIRST;
                    out_next.data = pkt_byte(upcin_pkg::OFS_FIRST, fmt_reg,
                                             word_next, pin_lvl);
                    out_next.last = 1'b0;
                    state_next    = ST_SEND;
                end
            end
            ST_SEND: begin
                if (pkt_ready_i) begin
                    if (out_reg.last) begin
                        state_next = ST_IDLE;
                    end else begin
                        ofs_next      = ofs_reg + 4'h1;
                        out_next.data = pkt_byte(ofs_next, cust_reg,
                                                 word_reg, snap_reg);
                        out_next.last = cust_reg ?
                            (ofs_next == upcin_pkg::OFS_DATA3) :
                            (ofs_next == upcin_pkg::OFS_DATA1);
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg    <= ST_IDLE;
            pend_reg     <= 1'b0;
            ofs_reg      <= upcin_pkg::OFS_FIRST;
            cust_reg     <= 1'b0;
            word_reg     <= upcin_pkg::REG_RST;
            snap_reg     <= upcin_pkg::PINS_RST;
            err_reg      <= 3'h0;
            lvl_prev_reg <= 4'h0;
            out_reg      <= '0;
        end else if (clk_en_i) begin
            state_reg    <= state_next;
            pend_reg     <= pend_next;
            ofs_reg      <= ofs_next;
            cust_reg     <= cust_next;
            word_reg     <= word_next;
            snap_reg     <= snap_next;
            err_reg      <= err_next;
            lvl_prev_reg <= lvl_prev_next;
            out_reg      <= out_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign hrdata_o    = hrdata_reg;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = upcin_pkg::HRESP_OKAY;
    assign pin_out_o   = pin_out_reg;
    assign pin_oe_o    = pin_dir_i;
    assign pkt_valid_o = (state_reg == ST_SEND);
    assign pkt_data_o  = out_reg.data;
    assign pkt_last_o  = out_reg.last;
    assign irq_o       = |(irq_st_reg & irq_msk_reg);

endmodule

//--- upcin_chk.sv
/* upcin_chk: assertions on the notification packet stream.
   assumes: bound into upcin_top; a packet starts after reset or a last. */
module upcin_chk (
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       arst_n_i,
    // packet stream
    input wire logic       pkt_valid_o,
    input wire logic       pkt_ready_i,
    input wire logic [7:0] pkt_data_o,
    input wire logic       pkt_last_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pos_reg;
    logic [3:0] pos_next;
    logic       take;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////
    // byte position inside the packet, back to zero after the last byte
    always_comb begin
        take     = pkt_valid_o & pkt_ready_i;
        pos_next = take ? (pkt_last_o ? 4'h0 : pos_reg + 4'h1) : pos_reg;
    end
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pos_reg <= 4'h0;
        end else begin
            pos_reg <= pos_next;
        end
    end
    a_req_type: assert property (take && pos_reg == 4'h0 |->
        pkt_data_o == 8'hA1) else $error("first byte wrong");
    a_notif_code: assert property (take && pos_reg == 4'h1 |->
        pkt_data_o == 8'h20) else $error("notification code wrong");
    a_zero_words: assert property (take && pos_reg inside {[2:5]} |->
        pkt_data_o == 8'h00) else $error("value or index not zero");
    a_len_low: assert property (take && pos_reg == 4'h6 |->
        pkt_data_o inside {8'h02, 8'h04}) else $error("length wrong");
    a_len_end: assert property (take && pkt_last_o |->
        pos_reg == 4'h9 || pos_reg == 4'hB) else $error("packet size wrong");
    a_data_top: assert property (take && pos_reg inside {7, 9} |->
        pkt_data_o == 8'h00 ##0 1) else $error("upper byte not zero");
    a_offer_hold: assert property (pkt_valid_o && !pkt_ready_i |=>
        pkt_valid_o && $stable(pkt_data_o) && $stable(pkt_last_o))
        else $error("offered byte changed");
    a_idle_gap: assert property (take && pkt_last_o |=> !pkt_valid_o)
        else $error("no idle cycle after packet");
    c_std: cover property (take && pkt_last_o && pos_reg == 4'h9);
    c_cust: cover property (take && pkt_last_o && pos_reg == 4'hB);
    c_stall: cover property (pkt_valid_o && !pkt_ready_i);
endmodule
bind upcin_top upcin_chk chk_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .pkt_valid_o(pkt_valid_o), .pkt_ready_i(pkt_ready_i),
    .pkt_data_o(pkt_data_o), .pkt_last_o(pkt_last_o));

//--- upcin_host.sv
/* upcin_host: usb host end, stores every notification byte taken.
   assumes: stall_i high makes ready toggle every cycle. */
module upcin_host (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    // control and stream
    input  wire logic       stall_i,
    input  wire logic       pkt_valid_i,
    input  wire logic [7:0] pkt_data_i,
    output logic            pkt_ready_o,
    output logic [5:0]      n_o,
    output logic [7:0]      rx_o [64]
);
    timeunit 1ns;
    timeprecision 1ps;
    // ready never waits for valid, so a slow host is still a legal one
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pkt_ready_o <= 1'b0;
            n_o         <= 6'h00;
        end else begin
            pkt_ready_o <= stall_i ? !pkt_ready_o : 1'b1;
            if (pkt_valid_i && pkt_ready_o) begin
                rx_o[n_o] <= pkt_data_i;
                n_o       <= n_o + 6'h01;
            end
        end
    end
endmodule

//--- tb_top.sv
/* tb_top: register, pin and packet scenarios for upcin_top.
   assumes: upcin_chk is bound in; upcin_host drains the packets. */
`define CHK(w, e, g) chk(w, 32'(e), 32'(g));
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, arst_n, hsel, hwrite, hready, irq, stall;
    logic        ovr, frm, ring, dsr, pv, pr, pl;
    logic        par, brk, dcd, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [5:0]  pin_in, pin_dir, pin_set, pin_out, pin_oe, n_rx;
    logic [7:0]  pd;
    logic [7:0]  rx [64];
    int          n_errors, n_checks, seen;
    upcin_top dut_u (.clk_sys_i(clk), .arst_n_i(arst_n), .clk_en_i(1'b1),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .pin_in_i(pin_in), .pin_dir_i(pin_dir), .pin_set_i(pin_set),
        .pin_out_o(pin_out), .pin_oe_o(pin_oe), .rx_overrun_i(ovr),
        .rx_parity_err_i(par), .rx_framing_err_i(frm), .ring_det_i(ring),
        .break_det_i(brk), .dsr_i(dsr), .dcd_i(dcd), .pkt_valid_o(pv),
        .pkt_ready_i(pr), .pkt_data_o(pd), .pkt_last_o(pl), .irq_o(irq));
    upcin_host host_u (.clk_sys_i(clk), .arst_n_i(arst_n), .stall_i(stall),
        .pkt_valid_i(pv), .pkt_data_i(pd), .pkt_ready_o(pr), .n_o(n_rx),
        .rx_o(rx));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string w, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // one single word transfer; r holds read data afterwards
    task automatic bus(logic wr, logic [9:0] idx, logic [31:0] wd);
        int k;
        k = 0;
        hsel   <= 1'b1;
        hwrite <= wr;
        htrans <= upcin_pkg::HTRANS_NONSEQ;
        haddr  <= {20'h00000, idx, 2'b00};
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 40);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 40);
        r = hrdata;
        if (k >= 40) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic pkt(logic cust, logic [7:0] d, logic [5:0] p);
        logic [7:0] e [12];
        int         n, k;
        n = cust ? 12 : 10;
        e = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, cust ? 8'h04 : 8'h02,
              8'h00, d, 8'h00, {2'b00, p}, 8'h00};
        for (k = 0; k < 300 && int'(n_rx) < seen + n; k++) tick(1);
        if (k == 300) begin
            n_errors++;
            summarize();
        end
        for (int i = 0; i < n; i++) begin
            `CHK("packet byte", e[i], rx[seen + i])
        end
        seen += n;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {arst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {pin_in, pin_dir, pin_set, ovr, frm, ring, dsr, stall} = '0;
        {par, brk, dcd} = '0;
        tick(4);
        arst_n <= 1'b1;
        tick(1);
        bus(0, upcin_pkg::IDX_PIN_MASK, 0);
        `CHK("mask reset", 16'h0000, r)
        `CHK("response okay", upcin_pkg::HRESP_OKAY, hresp)
        bus(0, upcin_pkg::IDX_FMT_SEL, 0);
        `CHK("format reset", 16'h0000, r)
        bus(0, upcin_pkg::IDX_PIN_STATUS, 0);
        `CHK("status reset", 16'h0000, r)
        bus(0, 10'h060, 0);
        `CHK("unmapped read", 32'h00000000, r)
        pin_in <= 6'h15;
        pkt(1'b0, 8'h00, 6'h15);
        bus(0, upcin_pkg::IDX_PIN_STATUS, 0);
        `CHK("pin status", 6'h15, r)
        bus(1, upcin_pkg::IDX_PIN_MASK, 32'h0000003F);
        pin_in <= 6'h2A;
        tick(30);
        `CHK("masked packets", seen, n_rx)
        bus(0, upcin_pkg::IDX_PIN_STATUS, 0);
        `CHK("masked status", 6'h2A, r)
        `CHK("irq masked", 1'b0, irq)
        bus(1, upcin_pkg::IDX_FMT_SEL, 32'h00000001);
        stall <= 1'b1;
        {ovr, frm, ring, dsr} <= 4'hF;
        tick(1);
        {ovr, frm} <= 2'h0;
        pkt(1'b1, 8'h5A, 6'h2A);
        bus(1, upcin_pkg::IDX_IRQ_MASK, 32'h00000002);
        tick(1);
        `CHK("irq raised", 1'b1, irq)
        bus(0, upcin_pkg::IDX_IRQ_STATUS, 0);
        `CHK("irq status", 3'h7, r)
        tick(1);
        `CHK("irq cleared", 1'b0, irq)
        pin_dir <= 6'h3F;
        pin_set <= 6'h3F;
        tick(1);
        pin_set <= 6'h00;
        pin_dir <= 6'h0C;
        bus(1, upcin_pkg::IDX_PIN_CLEAR, 32'h00000035);
        tick(1);
        `CHK("pin out", 6'h3B, pin_out)
        `CHK("pin enable", 6'h0C, pin_oe)
        // parity, break and carrier land in the remaining data bits
        {par, brk, dcd, ring, dsr} <= 5'h1C;
        tick(1);
        par <= 1'b0;
        pkt(1'b1, 8'h25, 6'h2A);
        summarize();
    end
endmodule
